// ==== ppcc_pkg.sv ====
// shared constants, types and decode for the charger control block
// assumes a single 50 MHz clock and comparator flags synchronous to it
package ppcc_pkg;

  localparam int CLK_MHZ = 50;
  localparam int TW = 22;

  // times in microseconds, counts in mclk cycles
  localparam int T_DEGLITCH_US = 50;
  localparam int T_WAIT_US = 32000;
  localparam int T_IDLE_US = 2000;
  localparam int T_HIGH_OFF_US = 2000;
  localparam int T_OVP_US = 115;
  localparam int T_BLINK_PERIOD_US = 100000;

  localparam int CYC_DEGLITCH = T_DEGLITCH_US * CLK_MHZ;
  localparam int CYC_WAIT = T_WAIT_US * CLK_MHZ;
  localparam int CYC_IDLE = T_IDLE_US * CLK_MHZ;
  localparam int CYC_HIGH_OFF = T_HIGH_OFF_US * CLK_MHZ;
  localparam int CYC_OVP = T_OVP_US * CLK_MHZ;
  localparam int CYC_BLINK_HALF = T_BLINK_PERIOD_US * CLK_MHZ / 2;

  localparam logic [4:0] PCNT_MAX = 5'h1f;
  localparam logic [9:0] ILIM_DEFAULT_MA = 10'h11d;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b11
  } ppcc_state_e;

  typedef enum logic [1:0] {
    PH_PRE = 2'b00,
    PH_FAST = 2'b01,
    PH_FULL = 2'b11
  } ppcc_phase_e;

  // pulse count to current limit in mA; other counts keep the old limit
  function automatic logic [9:0] ppcc_decode(input logic [4:0] n,
                                             input logic [9:0] cur);
    unique case (n)
      5'h04: ppcc_decode = 10'h05d;
      5'h05: ppcc_decode = 10'h0bb;
      5'h06: ppcc_decode = 10'h118;
      5'h07: ppcc_decode = 10'h176;
      5'h08: ppcc_decode = 10'h1d3;
      5'h09: ppcc_decode = 10'h28e;
      5'h0a: ppcc_decode = 10'h31a;
      5'h0b: ppcc_decode = 10'h3a7;
      default: ppcc_decode = cur;
    endcase
  endfunction

endpackage

// ==== ppcc_level_timer.sv ====
// registered level of an input and cycles since its last change
// assumes din synchronous to mclk; duration saturates at all ones
module ppcc_level_timer #(
  parameter int W = 22,
  parameter bit RST_LVL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic din,
  output logic lvl,
  output logic [W-1:0] dur
);
  import ppcc_pkg::*;

  typedef struct packed {
    logic lvl;
    logic [W-1:0] dur;
  } ppcc_lt_s;

  ppcc_lt_s s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.lvl = din;
    if (din != s_r.lvl) begin
      s_nxt.dur = '0;
    end else if (s_r.dur != {W{1'b1}}) begin
      s_nxt.dur = s_r.dur + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{lvl: RST_LVL, dur: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lvl = s_r.lvl;
  assign dur = s_r.dur;
endmodule

// ==== ppcc_blink.sv ====
// square wave with equal halves while enabled, driven phase first
// assumes en held for whole periods; drops back at once when en falls
module ppcc_blink #(
  parameter int HALF = 2500000,
  parameter int W = 22
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic en,
  output logic drive
);
  import ppcc_pkg::*;

  typedef struct packed {
    logic drive;
    logic [W-1:0] cnt;
  } ppcc_bl_s;

  ppcc_bl_s s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!en) begin
      s_nxt.cnt = '0;
      s_nxt.drive = 1'b1;
    end else if (s_r.cnt == W'(HALF - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.drive = !s_r.drive;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{drive: 1'b1, cnt: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign drive = s_r.drive;
endmodule

// ==== ppcc_top.sv ====
// control logic of the single-cell charger: pulse-count control pin,
// lockout, pack temperature window, status pin, die thermal limits.
// assumes comparator flags arrive synchronous to mclk and that mclk
// keeps running from the battery side while the input is absent.
//
// Functional notes
// R1: below lockout: ignore control, all off
// R2: above lockout: resume normal operation
// R3: pause charging outside pack temperature window
// R4: temperature pause still reports charging; the code blinks status instead (R9)
// R5: aux regulator on between lockout and overvoltage
// R6: status low during precharge or fast charge
// R7: status released when battery reaches overcharge
// R8: status low again on recharge start
// R9: temperature fault blinks status, 100ms, 50%
// R10: unpowered: status pin level gates temperature sense
// R11: control low, deglitch, 32ms wait, start
// R12: no command in wait: default 285mA
// R13: host keeps pulses and gaps 50-1000us
// R14: control low 2ms applies decoded count
// R15: host sends at most 16 pulses
// R16: counts 4-11 select limits, others unchanged
// R17: control high over 2ms disables device
// R18: die above regulation reduces charge current
// R19: die shutdown switch off, hysteresis restore
// R20: deglitched overvoltage turns charge and regulator off
// R21: start in precharge at or below exit threshold
// R22: recharge when battery falls below recharge threshold
// R23: time control levels, restart count each cycle
module ppcc_top #(
  parameter int WAIT_CYC = ppcc_pkg::CYC_WAIT,
  parameter int IDLE_CYC = ppcc_pkg::CYC_IDLE,
  parameter int HIGH_OFF_CYC = ppcc_pkg::CYC_HIGH_OFF,
  parameter int OVP_CYC = ppcc_pkg::CYC_OVP,
  parameter int BLINK_HALF_CYC = ppcc_pkg::CYC_BLINK_HALF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ctrl_in,
  input wire logic input_above_lockout,
  input wire logic input_above_overvoltage,
  input wire logic pack_temperature_sense_ok,
  input wire logic bat_above_precharge_exit,
  input wire logic bat_at_overcharge,
  input wire logic bat_below_recharge,
  input wire logic die_above_regulation,
  input wire logic die_above_shutdown,
  input wire logic die_below_shutdown_hys,
  input wire logic charge_status_output_i,
  output logic ldo_en,
  output logic charge_sw_en,
  output logic charge_reduce,
  output logic precharge_mode,
  output logic [9:0] input_current_limit_ma,
  output logic charge_status_output_o,
  output logic charge_status_output_oe,
  output logic pack_temperature_sense_en,
  output logic low_quiescent,
  output logic device_enabled
);
  import ppcc_pkg::*;

  if (WAIT_CYC < 1 || WAIT_CYC > 2**TW - 2 || IDLE_CYC < 1 ||
      IDLE_CYC > 2**TW - 2 || HIGH_OFF_CYC < 1 ||
      HIGH_OFF_CYC > 2**TW - 2 || OVP_CYC < 1 || OVP_CYC > 2**TW - 2 ||
      BLINK_HALF_CYC < 1 || BLINK_HALF_CYC > 2**TW - 1 ||
      CYC_DEGLITCH >= HIGH_OFF_CYC) begin : g_bad_param
    $error("ppcc_top: timing parameter out of range");
  end

  typedef struct packed {
    ppcc_state_e st;
    ppcc_phase_e ph;
    logic [4:0] pcnt;
    logic [TW-1:0] wcnt;
    logic ovp_trip;
    logic tsd;
    logic [9:0] ilim;
    logic ldo_en;
    logic sw_en;
    logic reduce;
    logic pre;
    logic chg_oe;
    logic ts_en;
    logic quiet;
    logic enabled;
  } ppcc_top_s;

  ppcc_top_s s_r, s_nxt;

  logic ctrl_lvl;
  logic [TW-1:0] ctrl_dur;
  logic ovp_lvl;
  logic [TW-1:0] ovp_dur;
  logic blink_drive;
  logic ts_fault;
  logic ctrl_fell;
  logic ctrl_disable;
  logic cmd_done;

  // control pin idles high (disabled) until proven low
  ppcc_level_timer #(.W(TW), .RST_LVL(1'b1)) u_ctrl_timer ( // R23
    .mclk(mclk),
    .rst_n(rst_n),
    .din(ctrl_in),
    .lvl(ctrl_lvl),
    .dur(ctrl_dur)
  );

  ppcc_level_timer #(.W(TW), .RST_LVL(1'b0)) u_ovp_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(input_above_overvoltage),
    .lvl(ovp_lvl),
    .dur(ovp_dur)
  );

  ppcc_blink #(.HALF(BLINK_HALF_CYC), .W(TW)) u_blink (
    .mclk(mclk),
    .rst_n(rst_n),
    .en(ts_fault),
    .drive(blink_drive)
  );

  // fault only counts while a charge cycle would otherwise run
  assign ts_fault = s_r.st == ST_RUN && !pack_temperature_sense_ok &&
                    input_above_lockout && !s_r.ovp_trip; // R3
  assign ctrl_fell = !ctrl_lvl && ctrl_dur == '0;
  assign ctrl_disable = ctrl_lvl && ctrl_dur == TW'(HIGH_OFF_CYC); // R17
  assign cmd_done = !ctrl_lvl && ctrl_dur == TW'(IDLE_CYC) &&
                    s_r.pcnt != '0; // R14

  always_comb begin
    s_nxt = s_r;
    // overvoltage trips after its deglitch, clears as soon as it drops
    if (ovp_lvl && input_above_overvoltage && ovp_dur == TW'(OVP_CYC)) begin
      s_nxt.ovp_trip = 1'b1; // R20
    end else if (!input_above_overvoltage) begin
      s_nxt.ovp_trip = 1'b0; // R20
    end
    if (die_above_shutdown) begin
      s_nxt.tsd = 1'b1; // R19
    end else if (die_below_shutdown_hys) begin
      s_nxt.tsd = 1'b0; // R19
    end
    unique case (s_r.st)
      ST_OFF: begin
        s_nxt.pcnt = '0;
        // a low already held through lockout enables at power-up
        if (input_above_lockout && !ctrl_lvl &&
            ctrl_dur >= TW'(CYC_DEGLITCH)) begin // R2
          s_nxt.st = ST_WAIT; // R11
          s_nxt.wcnt = '0;
          s_nxt.ilim = ILIM_DEFAULT_MA; // R12
        end
      end
      ST_WAIT: begin
        if (s_r.wcnt == TW'(WAIT_CYC - 1)) begin
          s_nxt.st = ST_RUN; // R11
          s_nxt.ph = bat_above_precharge_exit ? PH_FAST : PH_PRE; // R21
        end else begin
          s_nxt.wcnt = s_r.wcnt + 1'b1;
        end
      end
      ST_RUN: begin
        unique case (s_r.ph)
          PH_PRE: begin
            if (bat_above_precharge_exit) begin
              s_nxt.ph = PH_FAST;
            end
          end
          PH_FAST: begin
            if (bat_at_overcharge) begin
              s_nxt.ph = PH_FULL; // R7
            end
          end
          PH_FULL: begin
            if (bat_below_recharge) begin
              s_nxt.ph = PH_FAST; // R22
            end
          end
          default: s_nxt.ph = PH_PRE;
        endcase
      end
      default: s_nxt.st = ST_OFF;
    endcase
    // pulse counting runs through the wait and while running
    if (s_r.st != ST_OFF) begin
      if (cmd_done) begin
        s_nxt.ilim = ppcc_decode(s_r.pcnt, s_r.ilim); // R14 R16
        s_nxt.pcnt = '0; // R23
      end else if (ctrl_fell && s_r.pcnt != PCNT_MAX) begin
        s_nxt.pcnt = s_r.pcnt + 1'b1; // R23
      end
      if (ctrl_disable) begin
        s_nxt.st = ST_OFF; // R17
        s_nxt.pcnt = '0;
      end
    end
    // lockout overrides state and pulse count and holds the control pin ignored
    if (!input_above_lockout) begin
      s_nxt.st = ST_OFF; // R1
      s_nxt.pcnt = '0;
    end
    s_nxt.ldo_en = input_above_lockout && !s_nxt.ovp_trip; // R5 R20
    s_nxt.sw_en = input_above_lockout && !s_nxt.ovp_trip &&
                  s_r.st == ST_RUN && s_nxt.st == ST_RUN &&
                  pack_temperature_sense_ok && !s_nxt.tsd; // R1 R3 R19 R20
    s_nxt.reduce = s_nxt.sw_en && die_above_regulation; // R18
    s_nxt.pre = s_nxt.sw_en && s_r.ph == PH_PRE;
    // the blink takes precedence over the steady charging indication
    if (!input_above_lockout || s_r.st != ST_RUN || s_r.ovp_trip) begin
      s_nxt.chg_oe = 1'b0; // R1
    end else if (ts_fault) begin
      s_nxt.chg_oe = blink_drive; // R9 R4
    end else begin
      s_nxt.chg_oe = s_r.ph != PH_FULL; // R6 R7 R8
    end
    // unpowered, the host holding status low parks the sense divider
    s_nxt.ts_en = input_above_lockout || charge_status_output_i; // R10 R2
    s_nxt.quiet = input_above_lockout && s_nxt.st == ST_OFF; // R17
    s_nxt.enabled = s_nxt.st == ST_RUN;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: ST_OFF, ph: PH_PRE, pcnt: '0, wcnt: '0,
               ovp_trip: 1'b0, tsd: 1'b0, ilim: ILIM_DEFAULT_MA,
               ldo_en: 1'b0, sw_en: 1'b0, reduce: 1'b0, pre: 1'b0,
               chg_oe: 1'b0, ts_en: 1'b0, quiet: 1'b0, enabled: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ldo_en = s_r.ldo_en;
  assign charge_sw_en = s_r.sw_en;
  assign charge_reduce = s_r.reduce;
  assign precharge_mode = s_r.pre;
  assign input_current_limit_ma = s_r.ilim;
  assign charge_status_output_o = 1'b0;
  assign charge_status_output_oe = s_r.chg_oe;
  assign pack_temperature_sense_en = s_r.ts_en;
  assign low_quiescent = s_r.quiet;
  assign device_enabled = s_r.enabled;

  a_lockout_all_off: assert property ( // R1
    @(posedge mclk) disable iff (!rst_n)
    !input_above_lockout |=> !ldo_en && !charge_sw_en &&
      !charge_status_output_oe && s_r.st == ST_OFF)
    else $error("outputs active under lockout");

  a_ldo_window: assert property ( // R5
    @(posedge mclk) disable iff (!rst_n)
    input_above_lockout && !input_above_overvoltage |=> ldo_en)
    else $error("regulator off inside supply window");

  a_ts_pause: assert property ( // R3
    @(posedge mclk) disable iff (!rst_n)
    !pack_temperature_sense_ok |=> !charge_sw_en)
    else $error("charging outside pack temperature window");

  a_die_shutdown: assert property ( // R19
    @(posedge mclk) disable iff (!rst_n)
    die_above_shutdown |=> !charge_sw_en ##1 (s_r.tsd || !die_above_shutdown))
    else $error("charge switch on above die shutdown");

  a_ctrl_high_off: assert property ( // R17
    @(posedge mclk) disable iff (!rst_n)
    s_r.st != ST_OFF && ctrl_disable && input_above_lockout |=>
      s_r.st == ST_OFF && low_quiescent)
    else $error("long high on control did not disable");

  a_wait_to_run: assert property ( // R11
    @(posedge mclk) disable iff (!rst_n)
    s_r.st == ST_WAIT && s_r.wcnt == TW'(WAIT_CYC - 1) &&
      input_above_lockout && !ctrl_disable |=> s_r.st == ST_RUN)
    else $error("wait period did not end in start");

  a_default_limit: assert property ( // R12
    @(posedge mclk) disable iff (!rst_n)
    s_r.st == ST_OFF ##1 s_r.st == ST_WAIT |->
      input_current_limit_ma == ILIM_DEFAULT_MA)
    else $error("wait entered without default limit");

  a_decode_apply: assert property ( // R16
    @(posedge mclk) disable iff (!rst_n)
    s_r.st != ST_OFF && input_above_lockout && cmd_done |=>
      input_current_limit_ma == ppcc_decode($past(s_r.pcnt),
                                            $past(s_r.ilim)) &&
      s_r.pcnt == '0)
    else $error("pulse count not decoded into limit");

  a_status_charging: assert property ( // R6
    @(posedge mclk) disable iff (!rst_n)
    s_r.st == ST_RUN && s_r.ph != PH_FULL && !ts_fault &&
      input_above_lockout && !s_r.ovp_trip |=> charge_status_output_oe)
    else $error("status not driven while charging");

  a_status_blink: assert property ( // R9
    @(posedge mclk) disable iff (!rst_n)
    ts_fault && s_r.st == ST_RUN && input_above_lockout |=>
      charge_status_output_oe == $past(blink_drive))
    else $error("status does not follow fault blink");

  a_ovp_off: assert property ( // R20
    @(posedge mclk) disable iff (!rst_n)
    ovp_lvl && ovp_dur >= TW'(OVP_CYC) && input_above_overvoltage |=>
      !ldo_en && !charge_sw_en)
    else $error("regulator or switch on in overvoltage");

  a_sense_parked: assert property ( // R10
    @(posedge mclk) disable iff (!rst_n)
    !input_above_lockout && !charge_status_output_i |=>
      !pack_temperature_sense_en)
    else $error("sense on while unpowered and status held low");
endmodule

// ==== ppcc_host_model.sv ====
// host side of the control and status pins: pulses control, pulls the
// status pin up. assumes one bench process calls its tasks after edges.
module ppcc_host_model #(
  parameter int PULSE_CYC = 40,
  parameter int GAP_CYC = 40
) (
  input wire logic mclk,
  input wire logic status_o,
  input wire logic status_oe,
  output logic ctrl_in,
  output logic status_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_low;

  initial begin
    ctrl_in = 1'b1;
    hold_low = 1'b0;
  end

  // open drain: pull-up unless either side pulls low
  assign status_level = ((status_oe && !status_o) || hold_low) ? 1'b0 : 1'b1;

  task automatic hold(input logic v, input int n);
    @(posedge mclk);
    #2;
    ctrl_in = v;
    repeat (n - 1) @(posedge mclk);
    // return off the edge so callers never sample in its time step
    #2;
  endtask

  // widths scaled with the shortened idle time; leaves control low
  task automatic burst(input int n);
    for (int i = 0; i < n && i < 16; i++) begin
      hold(1'b1, PULSE_CYC);
      hold(1'b0, GAP_CYC);
    end
  endtask

  task automatic set_hold(input logic v);
    hold_low = v;
  endtask
endmodule

// ==== tb.sv ====
// self-checking bench of the charger control block with a host model.
// assumes shortened timing parameters; deglitch stays 2500 cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppcc_pkg::*;

  logic mclk, rst_n, lockout, ovp, ts_ok, bat_exit, bat_full, bat_rech;
  logic die_reg, die_sd, die_hys, ctrl_in, st_lvl;
  logic ldo_en, sw_en, reduce, pre, st_o, st_oe, ts_en, lowq, dev_en;
  logic [9:0] ilim;
  int fails, n_compared;

  // overvoltage keeps its full deglitch; the long waits are shortened
  ppcc_top #(.WAIT_CYC(200), .IDLE_CYC(100), .HIGH_OFF_CYC(3000),
    .BLINK_HALF_CYC(20)) ppcc_top_inst (
    .mclk(mclk), .rst_n(rst_n), .ctrl_in(ctrl_in),
    .input_above_lockout(lockout), .input_above_overvoltage(ovp),
    .pack_temperature_sense_ok(ts_ok), .bat_above_precharge_exit(bat_exit),
    .bat_at_overcharge(bat_full), .bat_below_recharge(bat_rech),
    .die_above_regulation(die_reg), .die_above_shutdown(die_sd),
    .die_below_shutdown_hys(die_hys), .charge_status_output_i(st_lvl),
    .ldo_en(ldo_en), .charge_sw_en(sw_en), .charge_reduce(reduce),
    .precharge_mode(pre), .input_current_limit_ma(ilim),
    .charge_status_output_o(st_o), .charge_status_output_oe(st_oe),
    .pack_temperature_sense_en(ts_en), .low_quiescent(lowq),
    .device_enabled(dev_en));

  ppcc_host_model ppcc_host_model_inst (
    .mclk(mclk), .status_o(st_o), .status_oe(st_oe),
    .ctrl_in(ctrl_in), .status_level(st_lvl));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [9:0] seen, input logic [9:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // bounded wait on the enable flag; running out ends the run
  task automatic wait_en(input logic v, output int k);
    for (k = 0; k < 3000 && dev_en !== v; k++) tick(1);
    if (dev_en !== v) begin
      check(dev_en, v, "enable wait ran out");
      give_verdict();
    end
  endtask

  // cycles the status enable keeps level v, capped
  task automatic run_len(input logic v, output int n);
    for (n = 0; st_oe === v && n < 200; n++) tick(1);
  endtask

  task automatic sc_unpowered();
    check(ilim, 10'h11d, "reset limit");
    check(ldo_en, 1'b0, "regulator on unpowered");
    check(st_oe, 1'b0, "status driven unpowered");
    check(ts_en, 1'b1, "sense off with pin high");
    ppcc_host_model_inst.set_hold(1'b1);
    tick(5);
    check(ts_en, 1'b0, "sense on with pin low");
    ppcc_host_model_inst.set_hold(1'b0);
    ppcc_host_model_inst.hold(1'b0, 3000);
    check(dev_en, 1'b0, "control honoured unpowered");
    check(sw_en, 1'b0, "switch on unpowered");
    check(ts_en, 1'b1, "sense off after release");
    ppcc_host_model_inst.hold(1'b1, 10);
    lockout = 1'b1;
    tick(5);
    check(ldo_en, 1'b1, "regulator off powered");
  endtask

  task automatic sc_enable();
    int k;
    ppcc_host_model_inst.hold(1'b0, 2400);
    check(dev_en, 1'b0, "enabled too early");
    wait_en(1'b1, k);
    check(10'(k > 250 && k < 350), 10'h001, "wait period length");
    // switch and status follow the enable flag by one edge
    tick(1);
    check(ilim, ILIM_DEFAULT_MA, "default limit");
    check(sw_en, 1'b1, "switch off while charging");
    check(st_oe, 1'b1, "status not low in precharge");
    check(pre, 1'b1, "not in precharge");
    check(st_lvl, 1'b0, "status pin not pulled low");
  endtask

  task automatic sc_commands();
    logic [9:0] tbl [0:7] = '{10'h05d, 10'h0bb, 10'h118, 10'h176,
                              10'h1d3, 10'h28e, 10'h31a, 10'h3a7};
    logic [9:0] prev, e;
    prev = 10'h11d;
    for (int n = 3; n <= 12; n++) begin
      e = (n >= 4 && n <= 11) ? tbl[n-4] : prev;
      ppcc_host_model_inst.burst(n);
      tick(30);
      check(ilim, prev, "limit changed before idle");
      tick(40);
      check(ilim, e, "decoded limit");
      prev = e;
    end
  endtask

  task automatic sc_temp();
    int h, l;
    ts_ok = 1'b0;
    tick(5);
    check(sw_en, 1'b0, "charging not paused");
    run_len(1'b1, h);
    run_len(1'b0, l);
    run_len(1'b1, h);
    run_len(1'b0, l);
    check(10'(h), 10'h014, "blink high time");
    check(10'(l), 10'h014, "blink low time");
    ts_ok = 1'b1;
    tick(5);
    check(sw_en, 1'b1, "charging not resumed");
    check(st_oe, 1'b1, "status not steady low");
  endtask

  task automatic sc_phases();
    bat_exit = 1'b1;
    tick(5);
    check(pre, 1'b0, "stuck in precharge");
    check(st_oe, 1'b1, "status not low in fast");
    bat_full = 1'b1;
    tick(5);
    check(st_oe, 1'b0, "status low when full");
    bat_full = 1'b0;
    bat_rech = 1'b1;
    tick(5);
    check(st_oe, 1'b1, "status not low on recharge");
    bat_rech = 1'b0;
  endtask

  task automatic sc_thermal();
    die_reg = 1'b1;
    tick(5);
    check(reduce, 1'b1, "no foldback");
    die_hys = 1'b0;
    die_sd = 1'b1;
    tick(5);
    check(sw_en, 1'b0, "switch on above shutdown");
    die_sd = 1'b0;
    tick(5);
    check(sw_en, 1'b0, "switch on inside hysteresis");
    die_hys = 1'b1;
    die_reg = 1'b0;
    tick(5);
    check(sw_en, 1'b1, "switch not restored");
    check(reduce, 1'b0, "foldback stuck");
  endtask

  task automatic sc_ovp();
    ovp = 1'b1;
    tick(5700);
    check(ldo_en, 1'b1, "overvoltage not deglitched");
    tick(60);
    check(ldo_en, 1'b0, "regulator on in overvoltage");
    check(sw_en, 1'b0, "switch on in overvoltage");
    ovp = 1'b0;
    tick(5);
    check(ldo_en, 1'b1, "regulator not back");
    check(sw_en, 1'b1, "switch not back");
  endtask

  // supply lost while running, control left low, then supply back
  task automatic sc_lockout();
    lockout = 1'b0;
    bat_exit = 1'b0;
    tick(10);
    check(ldo_en, 1'b0, "regulator on under lockout");
    check(sw_en, 1'b0, "switch on under lockout");
    check(st_oe, 1'b0, "status driven under lockout");
    check(dev_en, 1'b0, "control honoured under lockout");
    check(lowq, 1'b0, "low quiescent under lockout");
    check(ilim, 10'h3a7, "limit touched under lockout");
    lockout = 1'b1;
    ppcc_host_model_inst.burst(5);
    tick(30);
    check(ilim, ILIM_DEFAULT_MA, "no default on restart");
    tick(40);
    check(ilim, 10'h0bb, "pulses in wait not taken");
    check(dev_en, 1'b1, "not restarted after lockout");
    check(pre, 1'b1, "low battery not precharged");
  endtask

  task automatic sc_disable();
    int k;
    ppcc_host_model_inst.hold(1'b1, 2000);
    check(dev_en, 1'b1, "disabled too early");
    wait_en(1'b0, k);
    check(10'(k > 900 && k < 1100), 10'h001, "disable time");
    tick(2);
    check(lowq, 1'b1, "no low quiescent");
    check(sw_en, 1'b0, "charging after disable");
    check(ldo_en, 1'b1, "regulator follows control");
  endtask

  initial begin
    rst_n = 1'b0;
    lockout = 1'b0;
    ovp = 1'b0;
    ts_ok = 1'b1;
    bat_exit = 1'b0;
    bat_full = 1'b0;
    bat_rech = 1'b0;
    die_reg = 1'b0;
    die_sd = 1'b0;
    die_hys = 1'b1;
    fails = 0;
    n_compared = 0;
    tick(16);
    rst_n = 1'b1;
    tick(2);
    sc_unpowered();
    sc_enable();
    sc_commands();
    sc_temp();
    sc_phases();
    sc_thermal();
    sc_ovp();
    sc_lockout();
    sc_disable();
    give_verdict();
  end
endmodule
